// ===== core/cdp_map.svh
// Constants of the coefficient download parser: register offsets, field bits,
// characters, codes and limits. Included by its bare name.
`ifndef CDP_MAP_SVH
`define CDP_MAP_SVH
// Register byte offsets
`define CDP_OFS_CTRL 8'h00
`define CDP_OFS_CMD 8'h04
`define CDP_OFS_RESP 8'h08
`define CDP_OFS_STATUS 8'h0C
`define CDP_OFS_INT_STAT 8'h10
`define CDP_OFS_INT_MASK 8'h14
`define CDP_OFS_COEF_SEL 8'h18
`define CDP_OFS_COEF_DATA 8'h1C
`define CDP_HSIZE_WORD 3'b010
// Control bits
`define CDP_CTRL_V12 0
`define CDP_CTRL_NOCOMP 1
`define CDP_CTRL_ST_OFS 4
`define CDP_CTRL_ST_GAIN 5
`define CDP_CTRL_ST_CONV 6
// Event bits
`define CDP_EV_ACK 0
`define CDP_EV_ERR 1
`define CDP_EV_NVM 2
// Characters
`define CDP_CH_CMD 8'h76
`define CDP_CH_SPACE 8'h20
`define CDP_CH_MINUS 8'h2D
`define CDP_CH_DOT 8'h2E
`define CDP_CH_CR 8'h0D
`define CDP_CH_LF 8'h0A
// Formats
`define CDP_FMT_DEC 4'h0
`define CDP_FMT_HFLT 4'h1
`define CDP_FMT_HINT 4'h5
// Array indexes
`define CDP_AA_FIRST 8'h01
`define CDP_AA_LAST16 8'h10
`define CDP_AA_LAST12 8'h0C
`define CDP_AA_GLOBAL 8'h11
// Coefficient indexes
`define CDP_CC_C3 8'h05
`define CDP_CC_USER 8'h07
`define CDP_CC_MFG 8'h09
`define CDP_CC_RANGE 8'h0A
`define CDP_CC_PGAIN 8'h4D
`define CDP_CC_TGAIN 8'h4E
`define CDP_CC_G_SCALER 8'h01
`define CDP_CC_G_REF_LO 8'h04
`define CDP_CC_G_REF_HI 8'h07
`define CDP_CC_G_TREF 8'h18
// Storage slots
`define CDP_SLOT_USER 4'd6
`define CDP_SLOT_MFG 4'd7
`define CDP_SLOT_RANGE 4'd8
`define CDP_SLOT_PGAIN 4'd9
`define CDP_SLOT_TGAIN 4'd10
`define CDP_SLOT_G_REF 4'd1
`define CDP_SLOT_G_TREF 4'd5
`define CDP_GLOB_WORDS 6
`define CDP_BUF_DEPTH 8
// Limits
`define CDP_RESP_MAX 13'd300
`define CDP_DEC_CHARS 4'd13
`define CDP_HEX_CHARS 4'd9
`define CDP_DEC_DIGITS 4'd10
`define CDP_HEX_DIGITS 4'd8
// Responses: length in [31:24], first character in [7:0]
`define CDP_RESP_NONE 32'h00000000
`define CDP_RESP_ACK 32'h01000041
`define CDP_RESP_N01 32'h0331304E
`define CDP_RESP_N07 32'h0337304E
`define CDP_RESP_N08 32'h0338304E
`define CDP_SCALER_RST 32'h3F800000
`endif

// ===== core/cdp_pkg.sv
// Types shared by the coefficient download parser files.
// Assumes the constants of cdp_map.svh.
package cdp_pkg;
  typedef logic [31:0] cdp_word_t;
  typedef enum logic [3:0] {
    S_IDLE, S_FMT, S_AA_HI, S_AA_LO, S_CC1, S_CC2, S_DATA, S_DRAIN, S_EXEC
  } cdp_state_t;
endpackage : cdp_pkg

// ===== core/cdp_conv_if.sv
// Carrier between the parser and its decimal-to-float converter.
// Assumes both ends run combinationally on the same clock domain.
`timescale 1ns/1ps
`default_nettype none
interface cdp_conv_if;
  logic [33:0] mant;
  logic neg;
  logic [3:0] fdig;
  logic [31:0] flt;
  modport parser (output mant, output neg, output fdig, input flt);
  modport conv (input mant, input neg, input fdig, output flt);
endinterface : cdp_conv_if
`default_nettype wire

// ===== core/cdp_dec2flt.sv
// Decimal integer with a count of fraction digits to single float.
// Assumes a mantissa of at most ten decimal digits; truncates, no rounding.
`timescale 1ns/1ps
`default_nettype none
module cdp_dec2flt (
  // Conversion carrier
  cdp_conv_if.conv cv
);
  import cdp_pkg::*;

  logic [5:0] msb;
  logic [33:0] sh;
  logic [31:0] scl;
  logic [47:0] prod;
  logic [8:0] expo;
  logic [22:0] frac;

  // Powers of ten from one downward, as single floats
  function automatic logic [31:0] scale(input logic [3:0] k);
    case (k)
      4'h0: scale = 32'h3F800000;
      4'h1: scale = 32'h3DCCCCCD;
      4'h2: scale = 32'h3C23D70A;
      4'h3: scale = 32'h3A83126F;
      4'h4: scale = 32'h38D1B717;
      4'h5: scale = 32'h3727C5AC;
      4'h6: scale = 32'h358637BD;
      4'h7: scale = 32'h33D6BF95;
      4'h8: scale = 32'h322BCC77;
      default: scale = 32'h3089705F;
    endcase
  endfunction : scale

  always_comb begin
    msb = 6'h00;
    for (int i = 0; i < 34; i++) begin
      if (cv.mant[i]) begin
        msb = 6'(i);
      end
    end
    sh = cv.mant << (6'd33 - msb);
    scl = scale(cv.fdig);
    prod = sh[33:10] * {1'b1, scl[22:0]};
    expo = 9'(msb) + 9'(scl[30:23]) + 9'(prod[47]);
    frac = prod[47] ? prod[46:24] : prod[45:23];
    cv.flt = (cv.mant == 34'h0) ? 32'h00000000 : {cv.neg, expo[7:0], frac};
  end
endmodule : cdp_dec2flt
`default_nettype wire

// ===== core/cdp_parser.sv
// Coefficient download parser: AHB-Lite slave that takes command characters,
// parses the download command and writes the coefficient arrays.
// Assumes one AHB-Lite master, word transfers only, hready fed back from hreadyout.
// Behaviour
// RQ1: Response over 300 characters returns N07.
// RQ2: Download command fields stored into coefficients.
// RQ3: Accepted download answers single character A.
// RQ4: Format digit encodes all data, space-prefixed.
// RQ5: Format 0: signed decimal to float.
// RQ6: Formats 1, 5: eight hex digits.
// RQ7: Format not matching coefficient type: N08.
// RQ8: Array 01-10 channels, 11 global array.
// RQ9: Twelve-channel variant allows arrays 01-0C only.
// RQ10: Hyphen range fills consecutive coefficients.
// RQ11: Transducer array valid indexes and types.
// RQ12: Global array valid indexes, scaler defaults 1.0.
// RQ13: User field commits to non-volatile memory.
// RQ14: Uncompensated: reference, range, gain index commit.
// RQ15: Offset, gain stay volatile until store function.
// RQ16: Conversion coefficients persist via store function only.
// RQ17: Host encodes dates in user field.
// RQ18: Bad array or coefficient index: error, no writes.
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "cdp_map.svh"
module cdp_parser (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire cdp_pkg::cdp_word_t haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire cdp_pkg::cdp_word_t hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output cdp_pkg::cdp_word_t hrdata,
  // Interrupt
  output logic irq,
  // Non-volatile commit
  output logic nvm_commit,
  output logic [7:0] nvm_array,
  output logic [7:0] nvm_coef,
  output cdp_pkg::cdp_word_t nvm_data,
  // Store functions
  output logic store_offset_function,
  output logic store_gain_function,
  output logic store_conversion_coeff_function
);
  import cdp_pkg::*;

  cdp_conv_if cv ();
  cdp_dec2flt u_conv (.cv(cv));

  cdp_state_t st;
  logic [3:0] fmt, digs, clen, fdig, dcnt, exec_idx;
  logic [7:0] aa, cc1, cc2, dp_addr, ch, wr_cc;
  logic [1:0] ndig;
  logic [33:0] acc;
  logic neg, dot, dp_wr, v12, nocomp, resp_set, resp_valid;
  cdp_word_t err, resp_word, fail_code, hdr_err, datum_val, rmux, coef_rd;
  cdp_word_t bufw [0:`CDP_BUF_DEPTH-1];
  cdp_word_t chan_mem [0:255];
  cdp_word_t glob [0:`CDP_GLOB_WORDS-1];
  logic [2:0] int_stat, int_mask, ev;
  logic [15:0] coef_sel;
  logic [8:0] cnt;
  logic [4:0] hx;
  logic ap, wr_stb, char_stb, is_term, is_glob, aa_ok, too_long, idx_ok, fmt_ok;
  logic datum_ok, exec_start, exec_last, mem_we, sel_glob;

  function automatic logic [4:0] hexval(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) hexval = {1'b1, c[3:0]};
    else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) hexval = {1'b1, 4'(c[3:0] + 4'd9)};
    else hexval = 5'h00;
  endfunction : hexval

  // Contiguous group of valid indexes, zero when invalid
  function automatic logic [2:0] grp(input logic g, input logic [7:0] c);
    grp = 3'd0;
    if (g) begin
      if (c == `CDP_CC_G_SCALER) grp = 3'd1;
      else if (c >= `CDP_CC_G_REF_LO && c <= `CDP_CC_G_REF_HI) grp = 3'd2;
      else if (c == `CDP_CC_G_TREF) grp = 3'd3;
    end else begin
      if (c <= `CDP_CC_C3) grp = 3'd1;
      else if (c == `CDP_CC_USER) grp = 3'd2;
      else if (c == `CDP_CC_MFG || c == `CDP_CC_RANGE) grp = 3'd3;
      else if (c == `CDP_CC_PGAIN || c == `CDP_CC_TGAIN) grp = 3'd4;
    end
  endfunction : grp

  function automatic logic [3:0] slot(input logic g, input logic [7:0] c);
    if (g) begin
      if (c == `CDP_CC_G_TREF) slot = `CDP_SLOT_G_TREF;
      else if (c >= `CDP_CC_G_REF_LO) slot = 4'(c - `CDP_CC_G_REF_LO) + `CDP_SLOT_G_REF;
      else slot = 4'h0;
    end else begin
      case (c)
        `CDP_CC_USER: slot = `CDP_SLOT_USER;
        `CDP_CC_MFG: slot = `CDP_SLOT_MFG;
        `CDP_CC_RANGE: slot = `CDP_SLOT_RANGE;
        `CDP_CC_PGAIN: slot = `CDP_SLOT_PGAIN;
        `CDP_CC_TGAIN: slot = `CDP_SLOT_TGAIN;
        default: slot = c[3:0];
      endcase
    end
  endfunction : slot

  assign cv.mant = acc;
  assign cv.neg = neg;
  assign cv.fdig = fdig;
  assign mem_we = (st == S_EXEC);
  assign wr_cc = cc1 + 8'(exec_idx);

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  always_comb begin
    ch = hwdata[7:0];
    hx = hexval(ch);
    is_term = (ch == `CDP_CH_CR) || (ch == `CDP_CH_LF);
    is_glob = (aa == `CDP_AA_GLOBAL);
    aa_ok = is_glob || (aa >= `CDP_AA_FIRST && aa <= (v12 ? `CDP_AA_LAST12 : `CDP_AA_LAST16)); // [RQ8] [RQ9]
    cnt = 9'(cc2) - 9'(cc1) + 9'd1;
    too_long = (cc2 >= cc1) && (13'(cnt) * 13'(fmt == `CDP_FMT_DEC ? `CDP_DEC_CHARS : `CDP_HEX_CHARS) > `CDP_RESP_MAX); // [RQ1]
    idx_ok = aa_ok && (cc1 <= cc2) && (grp(is_glob, cc1) != 3'd0) && (grp(is_glob, cc1) == grp(is_glob, cc2)); // [RQ11] [RQ12] [RQ18]
    fmt_ok = (!is_glob && cc1 >= `CDP_CC_USER) ? (fmt == `CDP_FMT_HINT) : (fmt == `CDP_FMT_DEC || fmt == `CDP_FMT_HFLT); // [RQ7]
    if (too_long) hdr_err = `CDP_RESP_N07; // [RQ1]
    else if (!idx_ok) hdr_err = `CDP_RESP_N01; // [RQ18]
    else if (!fmt_ok) hdr_err = `CDP_RESP_N08; // [RQ7]
    else hdr_err = `CDP_RESP_NONE;
    datum_ok = (fmt == `CDP_FMT_DEC) ? (digs != 4'd0) : (digs == `CDP_HEX_DIGITS); // [RQ5] [RQ6]
    datum_val = (fmt == `CDP_FMT_DEC) ? cv.flt : acc[31:0];
    fail_code = `CDP_RESP_NONE;
    case (st)
      S_FMT: if (!hx[4] || ch[6]) fail_code = `CDP_RESP_N01; // [RQ4]
      S_AA_HI, S_AA_LO: if (!hx[4]) fail_code = `CDP_RESP_N01;
      S_CC1, S_CC2: begin
        if (ch == `CDP_CH_SPACE && ndig != 2'd0) fail_code = hdr_err;
        else if (!(hx[4] && ndig != 2'd2) && !(st == S_CC1 && ch == `CDP_CH_MINUS && ndig != 2'd0))
          fail_code = `CDP_RESP_N01; // [RQ10]
      end
      S_DATA: begin
        if (ch == `CDP_CH_SPACE || is_term) begin
          if (!datum_ok) fail_code = `CDP_RESP_N08;
          else if (9'(dcnt) >= cnt || (is_term && 9'(dcnt) + 9'd1 != cnt)) fail_code = `CDP_RESP_N01;
        end else if (fmt == `CDP_FMT_DEC) begin
          if (clen >= `CDP_DEC_CHARS) fail_code = `CDP_RESP_N08; // [RQ5]
          else if (ch == `CDP_CH_MINUS) fail_code = (clen == 4'd1) ? `CDP_RESP_NONE : `CDP_RESP_N08;
          else if (ch == `CDP_CH_DOT) fail_code = (!dot && digs != 4'd0) ? `CDP_RESP_NONE : `CDP_RESP_N08;
          else if (!(hx[4] && !ch[6]) || digs >= `CDP_DEC_DIGITS) fail_code = `CDP_RESP_N08;
        end else if (!hx[4] || digs >= `CDP_HEX_DIGITS) begin
          fail_code = `CDP_RESP_N08; // [RQ6]
        end
      end
      default: fail_code = `CDP_RESP_NONE;
    endcase
    exec_start = char_stb && st == S_DATA && is_term && fail_code == `CDP_RESP_NONE;
    exec_last = (9'(exec_idx) + 9'd1 == cnt);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parser state machine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= S_IDLE;
      {fmt, digs, clen, fdig, dcnt, exec_idx} <= '0;
      {aa, cc1, cc2, ndig, acc, neg, dot} <= '0;
      err <= `CDP_RESP_NONE;
      resp_word <= `CDP_RESP_NONE;
      resp_set <= 1'b0;
      for (int i = 0; i < `CDP_BUF_DEPTH; i++) bufw[i] <= '0;
    end else begin
      resp_set <= 1'b0;
      if (char_stb && st != S_IDLE && st != S_DRAIN && fail_code != `CDP_RESP_NONE) begin
        err <= fail_code;
        st <= is_term ? S_IDLE : S_DRAIN; // [RQ18]
        resp_set <= is_term;
        resp_word <= is_term ? fail_code : resp_word;
      end else begin
        case (st)
          S_IDLE: if (char_stb && ch == `CDP_CH_CMD) begin
            st <= S_FMT; // [RQ2]
            {dcnt, ndig, exec_idx} <= '0;
            {cc1, cc2} <= '0; // [RQ10]
            err <= `CDP_RESP_NONE;
          end
          S_FMT: if (char_stb) begin
            fmt <= hx[3:0]; // [RQ4]
            st <= S_AA_HI;
          end
          S_AA_HI: if (char_stb) begin
            aa <= {hx[3:0], 4'h0};
            st <= S_AA_LO;
          end
          S_AA_LO: if (char_stb) begin
            aa <= {aa[7:4], hx[3:0]};
            st <= S_CC1;
          end
          S_CC1, S_CC2: if (char_stb) begin
            if (ch == `CDP_CH_MINUS) begin
              ndig <= 2'd0; // [RQ10]
              cc2 <= 8'h00;
              st <= S_CC2;
            end else if (ch == `CDP_CH_SPACE) begin
              {acc, neg, dot, fdig, digs} <= '0;
              clen <= 4'd1;
              st <= S_DATA;
            end else begin
              ndig <= ndig + 2'd1;
              cc2 <= {cc2[3:0], hx[3:0]};
              if (st == S_CC1) cc1 <= {cc1[3:0], hx[3:0]};
            end
          end
          S_DATA: if (char_stb) begin
            clen <= clen + 4'd1;
            if (ch == `CDP_CH_SPACE || is_term) begin
              bufw[dcnt[2:0]] <= datum_val; // [RQ5] [RQ6]
              dcnt <= dcnt + 4'd1;
              {acc, neg, dot, fdig, digs} <= '0;
              clen <= 4'd1;
              if (is_term) st <= S_EXEC;
            end else if (fmt != `CDP_FMT_DEC) begin
              acc <= {2'b00, acc[27:0], hx[3:0]};
              digs <= digs + 4'd1;
            end else if (ch == `CDP_CH_MINUS) begin
              neg <= 1'b1;
            end else if (ch == `CDP_CH_DOT) begin
              dot <= 1'b1;
            end else begin
              acc <= 34'({acc, 3'b000} + {acc, 1'b0} + 37'(hx[3:0]));
              digs <= digs + 4'd1;
              if (dot) fdig <= fdig + 4'd1;
            end
          end
          S_DRAIN: if (char_stb && is_term) begin
            st <= S_IDLE;
            resp_set <= 1'b1;
            resp_word <= err;
          end
          S_EXEC: begin
            exec_idx <= exec_idx + 4'd1; // [RQ10]
            if (exec_last) begin
              st <= S_IDLE;
              resp_set <= 1'b1;
              resp_word <= `CDP_RESP_ACK; // [RQ3]
            end
          end
          default: st <= S_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Coefficient storage
  always_ff @(posedge hclk) begin
    if (mem_we && !is_glob) chan_mem[{4'(aa[3:0] - 4'd1), slot(1'b0, wr_cc)}] <= bufw[exec_idx[2:0]]; // [RQ2] [RQ15]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `CDP_GLOB_WORDS; i++) glob[i] <= (i == 0) ? `CDP_SCALER_RST : 32'h00000000; // [RQ12]
    end else if (mem_we && is_glob) begin
      glob[3'(slot(1'b1, wr_cc))] <= bufw[exec_idx[2:0]];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {nvm_commit, nvm_array, nvm_coef, nvm_data} <= '0;
    end else begin
      nvm_commit <= mem_we && !is_glob && (wr_cc == `CDP_CC_USER || (nocomp && (wr_cc == `CDP_CC_MFG ||
                    wr_cc == `CDP_CC_RANGE || wr_cc == `CDP_CC_PGAIN))); // [RQ13] [RQ14] [RQ15] [RQ16]
      nvm_array <= aa;
      nvm_coef <= wr_cc;
      nvm_data <= bufw[exec_idx[2:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave and registers
  assign ap = hsel && htrans[1] && hready && (hsize == `CDP_HSIZE_WORD);
  assign wr_stb = dp_wr && hreadyout;
  assign char_stb = wr_stb && (dp_addr == `CDP_OFS_CMD);
  assign sel_glob = (coef_sel[15:8] == `CDP_AA_GLOBAL);
  assign ev = {nvm_commit, resp_set && resp_word != `CDP_RESP_ACK, resp_set && resp_word == `CDP_RESP_ACK};

  always_comb begin
    coef_rd = 32'h00000000;
    if (grp(sel_glob, coef_sel[7:0]) != 3'd0) begin
      if (sel_glob) coef_rd = glob[3'(slot(1'b1, coef_sel[7:0]))];
      else if (coef_sel[15:8] >= `CDP_AA_FIRST && coef_sel[15:8] <= `CDP_AA_LAST16)
        coef_rd = chan_mem[{4'(coef_sel[11:8] - 4'd1), slot(1'b0, coef_sel[7:0])}];
    end
    case (haddr[7:0])
      `CDP_OFS_CTRL: rmux = {30'h0, nocomp, v12};
      `CDP_OFS_RESP: rmux = resp_word;
      `CDP_OFS_STATUS: rmux = {30'h0, resp_valid, st != S_IDLE};
      `CDP_OFS_INT_STAT: rmux = {29'h0, int_stat};
      `CDP_OFS_INT_MASK: rmux = {29'h0, int_mask};
      `CDP_OFS_COEF_SEL: rmux = {16'h0, coef_sel};
      `CDP_OFS_COEF_DATA: rmux = coef_rd;
      default: rmux = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {dp_wr, dp_addr, hrdata, hresp} <= '0;
      hreadyout <= 1'b1;
    end else begin
      hresp <= 1'b0;
      hreadyout <= !(exec_start || (st == S_EXEC && !exec_last));
      if (hready) begin
        dp_wr <= ap && hwrite;
        dp_addr <= haddr[7:0];
      end
      if (ap && !hwrite) hrdata <= rmux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {v12, nocomp, int_mask, coef_sel} <= '0;
      {store_offset_function, store_gain_function, store_conversion_coeff_function} <= '0;
    end else begin
      store_offset_function <= wr_stb && dp_addr == `CDP_OFS_CTRL && hwdata[`CDP_CTRL_ST_OFS]; // [RQ15]
      store_gain_function <= wr_stb && dp_addr == `CDP_OFS_CTRL && hwdata[`CDP_CTRL_ST_GAIN]; // [RQ15]
      store_conversion_coeff_function <= wr_stb && dp_addr == `CDP_OFS_CTRL && hwdata[`CDP_CTRL_ST_CONV] && nocomp; // [RQ16]
      if (wr_stb && dp_addr == `CDP_OFS_CTRL) {nocomp, v12} <= {hwdata[`CDP_CTRL_NOCOMP], hwdata[`CDP_CTRL_V12]};
      if (wr_stb && dp_addr == `CDP_OFS_INT_MASK) int_mask <= hwdata[2:0];
      if (wr_stb && dp_addr == `CDP_OFS_COEF_SEL) coef_sel <= hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {int_stat, resp_valid, irq} <= '0;
    end else begin
      int_stat <= (int_stat & ~((wr_stb && dp_addr == `CDP_OFS_INT_STAT) ? hwdata[2:0] : 3'h0)) | ev;
      resp_valid <= resp_set || (resp_valid && !(ap && !hwrite && haddr[7:0] == `CDP_OFS_RESP));
      irq <= |(int_stat & int_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_hdr_space;
    char_stb && (st == S_CC1 || st == S_CC2) && ch == `CDP_CH_SPACE && ndig != 2'd0;
  endsequence
  sequence s_hex_push;
    char_stb && st == S_DATA && fmt != `CDP_FMT_DEC && (ch == `CDP_CH_SPACE || is_term) &&
      fail_code == `CDP_RESP_NONE;
  endsequence

  property p_n07;
    s_hdr_space ##0 too_long |=> st == S_DRAIN && err == `CDP_RESP_N07;
  endproperty
  a_n07: assert property (p_n07) else $error("long range not refused"); // [RQ1]
  property p_n08;
    s_hdr_space ##0 (!too_long && idx_ok && !fmt_ok) |=> err == `CDP_RESP_N08;
  endproperty
  a_n08: assert property (p_n08) else $error("format mismatch not refused"); // [RQ7]
  property p_badidx;
    s_hdr_space ##0 (!too_long && !idx_ok) |=> err == `CDP_RESP_N01 ##1 !mem_we;
  endproperty
  a_badidx: assert property (p_badidx) else $error("bad index not refused"); // [RQ18]
  property p_arr12;
    s_hdr_space ##0 (!too_long && v12 && aa > `CDP_AA_LAST12 && aa <= `CDP_AA_LAST16) |=> err == `CDP_RESP_N01;
  endproperty
  a_arr12: assert property (p_arr12) else $error("array beyond twelve accepted"); // [RQ9]
  property p_ack;
    exec_start |=> mem_we ##[1:8] (resp_set && resp_word == `CDP_RESP_ACK);
  endproperty
  a_ack: assert property (p_ack) else $error("no acknowledge after download"); // [RQ3]
  property p_consec;
    mem_we ##1 mem_we |-> wr_cc == $past(wr_cc) + 8'd1;
  endproperty
  a_consec: assert property (p_consec) else $error("range not consecutive"); // [RQ10]
  property p_user_nvm;
    mem_we && !is_glob && wr_cc == `CDP_CC_USER |=> nvm_commit && nvm_coef == `CDP_CC_USER;
  endproperty
  a_user_nvm: assert property (p_user_nvm) else $error("user field not committed"); // [RQ13]
  property p_nocomp_nvm;
    mem_we && !is_glob && (wr_cc == `CDP_CC_MFG || wr_cc == `CDP_CC_RANGE || wr_cc == `CDP_CC_PGAIN)
      |=> nvm_commit == $past(nocomp);
  endproperty
  a_nocomp_nvm: assert property (p_nocomp_nvm) else $error("commit does not follow compensation"); // [RQ14]
  property p_volatile;
    mem_we && wr_cc <= `CDP_CC_C3 |=> !nvm_commit;
  endproperty
  a_volatile: assert property (p_volatile) else $error("volatile term committed"); // [RQ15] [RQ16]
  property p_hexdat;
    s_hex_push |=> bufw[$past(dcnt[2:0])] == $past(acc[31:0]);
  endproperty
  a_hexdat: assert property (p_hexdat) else $error("hex datum not stored"); // [RQ6]
endmodule : cdp_parser
`default_nettype wire

// ===== core/cdp_conv_if_unused_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== tb/cdp_nvm_model.sv
// Non-volatile memory side of the parser: counts commits and store pulses.
// Assumes one-cycle pulses from the parser on hclk.
`timescale 1ns/1ps
`default_nettype none
module cdp_nvm_model (
  // Clock
  input wire logic hclk,
  // Commit and store pulses
  input wire logic nvm_commit,
  input wire cdp_pkg::cdp_word_t nvm_data,
  input wire logic [2:0] store,
  // Location of the commit
  input wire logic [15:0] nvm_loc
);
  import cdp_pkg::*;
  int commits = 0;
  int stores = 0;
  cdp_word_t last = 32'h0;
  cdp_word_t last_loc = 32'h0;
  always_ff @(posedge hclk) begin
    if (nvm_commit) begin
      commits <= commits + 1;
      last <= nvm_data;
      last_loc <= {16'h0, nvm_loc};
    end
    stores <= stores + store[0] + store[1] + store[2];
  end
endmodule : cdp_nvm_model
`default_nettype wire

// ===== tb/test_coefficient_download_parser.sv
// Self-checking bench for the coefficient download parser over AHB-Lite.
// Assumes zero wait states except while a download executes.
`timescale 1ns/1ps
`default_nettype none
`include "cdp_map.svh"
module test_coefficient_download_parser;
  import cdp_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = `CDP_HSIZE_WORD;
  cdp_word_t haddr = 32'h0;
  cdp_word_t hwdata = 32'h0;
  logic hreadyout, hresp, irq, nvm_commit, st_ofs, st_gain, st_conv;
  cdp_word_t hrdata, nvm_data, rd;
  logic [7:0] nvm_array, nvm_coef;
  int bad_count = 0;
  int checks = 0;
  int c;
  always #5 hclk = ~hclk;
  cdp_parser cdp_parser_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irq(irq), .nvm_commit(nvm_commit), .nvm_array(nvm_array), .nvm_coef(nvm_coef),
    .nvm_data(nvm_data),
    .store_offset_function(st_ofs), .store_gain_function(st_gain), .store_conversion_coeff_function(st_conv));
  cdp_nvm_model cdp_nvm_model_inst (.hclk(hclk), .nvm_commit(nvm_commit), .nvm_data(nvm_data),
    .store({st_conv, st_gain, st_ofs}), .nvm_loc({nvm_array, nvm_coef}));
  ////////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("Checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task chk(input string nm, input cdp_word_t got, input cdp_word_t exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Bounded wait for hready at the next edges
  task wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 200) begin
        bad_count++;
        close_out;
      end
      @(posedge hclk);
    end
  endtask : wait_rdy
  task bus(input logic w, input logic [7:0] a, input cdp_word_t d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask : bus
  // One character per write, LF ends it, then poll for the response
  task cmd(input string s, input cdp_word_t exp);
    int n;
    for (int i = 0; i < s.len(); i++) bus(1'b1, `CDP_OFS_CMD, {24'h0, s[i]});
    bus(1'b1, `CDP_OFS_CMD, {24'h0, `CDP_CH_LF});
    n = 0;
    rd = 32'h0;
    while (rd[1] !== 1'b1 && n < 50) begin
      bus(1'b0, `CDP_OFS_STATUS, 32'h0);
      n++;
    end
    if (rd[1] !== 1'b1) begin
      bad_count++;
      close_out;
    end
    bus(1'b0, `CDP_OFS_RESP, 32'h0);
    chk(s, rd, exp);
  endtask : cmd
  task coef(input logic [15:0] sel, input cdp_word_t exp);
    bus(1'b1, `CDP_OFS_COEF_SEL, {16'h0, sel});
    bus(1'b0, `CDP_OFS_COEF_DATA, 32'h0);
    chk("coef", rd, exp);
  endtask : coef
  ////////////////////////////////////////////////////////////////////////////////
  task t_user;
    bus(1'b0, `CDP_OFS_STATUS, 32'h0);
    chk("status", rd, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    coef(16'h1101, `CDP_SCALER_RST);
    bus(1'b1, `CDP_OFS_INT_MASK, 32'h7);
    c = cdp_nvm_model_inst.commits;
    cmd("v50107 00241231", `CDP_RESP_ACK);
    coef(16'h0107, 32'h00241231);
    chk("commits", cdp_nvm_model_inst.commits - c, 32'h1);
    chk("nvm_data", cdp_nvm_model_inst.last, 32'h00241231);
    chk("nvm_loc", cdp_nvm_model_inst.last_loc, 32'h0107);
    chk("irq", {31'h0, irq}, 32'h1);
    bus(1'b1, `CDP_OFS_INT_STAT, 32'h7);
    repeat (2) @(posedge hclk);
    chk("irq", {31'h0, irq}, 32'h0);
    $display("Test user field done");
  endtask : t_user
  task t_range;
    c = cdp_nvm_model_inst.commits;
    cmd("v00800-01 0.000 1.000", `CDP_RESP_ACK);
    coef(16'h0800, 32'h0);
    coef(16'h0801, 32'h3F800000);
    cmd("v00102 -2.5", `CDP_RESP_ACK);
    coef(16'h0102, 32'hC0200000);
    cmd("v0082 1", `CDP_RESP_ACK);
    coef(16'h0802, 32'h3F800000);
    chk("commits", cdp_nvm_model_inst.commits - c, 32'h0);
    cmd("v11101 40000000", `CDP_RESP_ACK);
    coef(16'h1101, 32'h40000000);
    $display("Test range done");
  endtask : t_range
  task t_errs;
    cmd("v10107 12345678", `CDP_RESP_N08);
    cmd("v51207 00000001", `CDP_RESP_N01);
    cmd("v00100-4E 1", `CDP_RESP_N07);
    coef(16'h0107, 32'h00241231);
    $display("Test errors done");
  endtask : t_errs
  task t_var;
    bus(1'b1, `CDP_OFS_CTRL, 32'h3);
    cmd("v50D09 00000001", `CDP_RESP_N01);
    c = cdp_nvm_model_inst.commits;
    cmd("v50C09 00000005", `CDP_RESP_ACK);
    chk("commits", cdp_nvm_model_inst.commits - c, 32'h1);
    chk("nvm_loc", cdp_nvm_model_inst.last_loc, 32'h0C09);
    c = cdp_nvm_model_inst.stores;
    bus(1'b1, `CDP_OFS_CTRL, 32'h73);
    repeat (3) @(posedge hclk);
    chk("stores", cdp_nvm_model_inst.stores - c, 32'h3);
    bus(1'b1, `CDP_OFS_CTRL, 32'h0);
    c = cdp_nvm_model_inst.stores;
    bus(1'b1, `CDP_OFS_CTRL, 32'h40);
    repeat (3) @(posedge hclk);
    chk("stores", cdp_nvm_model_inst.stores - c, 32'h0);
    bus(1'b1, `CDP_OFS_CTRL, 32'h0);
    $display("Test variant done");
  endtask : t_var
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_user;
    t_range;
    t_errs;
    t_var;
    close_out;
  end
endmodule : test_coefficient_download_parser
`default_nettype wire
